// ==== logic/vrus_pkg.sv ====
// Shared constants and carriers for the vertical ring usage event counter
package vrus_pkg;

  // Event codes picking the ring to count
  localparam logic [7:0] VRUS_EVT_CREDIT  = 8'hb4;
  localparam logic [7:0] VRUS_EVT_ACK     = 8'hb1;
  localparam logic [7:0] VRUS_EVT_PAYLOAD = 8'hb2;
  localparam logic [7:0] VRUS_EVT_INVAL   = 8'hb3;
  localparam logic [7:0] VRUS_EVT_TERT    = 8'hb5;

  // Qualifier field in the control word, bits [15:8]
  localparam int VRUS_QUAL_LSB = 8;
  localparam int VRUS_QUAL_W   = 8;

  // Qualifier bit positions inside the qualifier field (bit 8 is position 0)
  localparam int VRUS_Q_ASC_EVEN  = 0;
  localparam int VRUS_Q_ASC_ODD   = 1;
  localparam int VRUS_Q_DESC_EVEN = 2;
  localparam int VRUS_Q_DESC_ODD  = 3;

  // Physical lane indices of one vertical ring
  localparam int VRUS_LANES       = 4;
  localparam int VRUS_PHY_CW_EVEN = 0;
  localparam int VRUS_PHY_CW_ODD  = 1;
  localparam int VRUS_PHY_CCW_EVN = 2;
  localparam int VRUS_PHY_CCW_ODD = 3;
  localparam int VRUS_DIR_FLIP    = 2;

  localparam int VRUS_RINGS = 5;

  // Reset values
  localparam logic VRUS_INC_RST  = 1'b0;
  localparam logic VRUS_SIDE_RST = 1'b0;

  typedef enum logic [2:0] {
    VRUS_SEL_CREDIT  = 3'b000,
    VRUS_SEL_ACK     = 3'b001,
    VRUS_SEL_PAYLOAD = 3'b010,
    VRUS_SEL_INVAL   = 3'b011,
    VRUS_SEL_TERT    = 3'b100,
    VRUS_SEL_NONE    = 3'b111
  } vrus_ring_sel_t;

  typedef struct packed {
    logic [VRUS_QUAL_W-1:0] qualifier;
    logic [7:0]             event_code;
  } vrus_ctl_t;

  typedef struct packed {
    logic passing;
    logic sinking;
    logic injecting;
  } vrus_lane_t;

  typedef vrus_lane_t [VRUS_LANES-1:0] vrus_ring_t;
  typedef vrus_ring_t [VRUS_RINGS-1:0] vrus_stop_t;

endpackage

// ==== logic/vrus_ring_usage_counter.sv ====
// Vertical ring usage event selection and per-cycle increment generation
`timescale 1ns/10ps

// How it works
// - Code 0xb4 counts cycles the acknowledge-credit ring is busy, qualified.
// - Code 0xb1 counts acknowledge ring busy cycles by direction and parity.
// - Code 0xb2 counts payload ring busy cycles by direction and parity.
// - Code 0xb3 counts busy cycles of the single invalidate ring by direction.
// - Code 0xb5 counts tertiary ring busy cycles by direction and parity.
// - Busy means passing or sinking; injection alone is not busy.
// - Qualifier bits 8..11: ascending even, ascending odd, descending even, odd.
// - Left stops: ascending is clockwise; right stops swap the mapping.
// - First half of slices are left side, second half right side.
// - Invalidate event: bit 8 ascending, bit 10 descending; software sets both.
module vrus_ring_usage_counter #(
  parameter int SLICE_COUNT = 40,
  parameter int SLICE_ID_W  = 6
) (
  input  wire logic                    core_clk,
  input  wire logic                    rst_n,
  input  vrus_pkg::vrus_ctl_t          ctl,
  input  wire logic                    count_enable,
  input  wire logic [SLICE_ID_W-1:0]   slice_id,
  input  vrus_pkg::vrus_stop_t         activity,
  output logic                         count_inc,
  output logic                         event_known,
  output logic                         stop_on_right,
  output logic [vrus_pkg::VRUS_LANES-1:0] lane_busy
);
  import vrus_pkg::*;

  localparam logic [SLICE_ID_W-1:0] HALF_SLICES = SLICE_ID_W'(SLICE_COUNT / 2);

  if (SLICE_COUNT < 2 || SLICE_COUNT > (1 << SLICE_ID_W)) begin : g_bad_cfg
    $error("SLICE_COUNT must be 2..2**SLICE_ID_W");
  end

  vrus_ring_sel_t               sel;
  logic [VRUS_LANES-1:0]        phys_busy [VRUS_RINGS];
  logic [VRUS_LANES-1:0]        logic_busy [VRUS_RINGS];
  logic [VRUS_LANES-1:0]        qual_mask;
  logic [VRUS_LANES-1:0]        sel_busy;
  logic [VRUS_LANES-1:0]        hit_lanes;
  logic                         side_right_q;
  logic                         count_inc_q;
  logic                         event_known_q;
  logic [VRUS_LANES-1:0]        lane_busy_q;

  // Event code decode
  always_comb begin
    unique case (ctl.event_code)
      VRUS_EVT_CREDIT:  sel = VRUS_SEL_CREDIT;
      VRUS_EVT_ACK:     sel = VRUS_SEL_ACK;
      VRUS_EVT_PAYLOAD: sel = VRUS_SEL_PAYLOAD;
      VRUS_EVT_INVAL:   sel = VRUS_SEL_INVAL;
      VRUS_EVT_TERT:    sel = VRUS_SEL_TERT;
      default:          sel = VRUS_SEL_NONE;
    endcase
  end

  // Side of the ring from the slice position
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      side_right_q <= VRUS_SIDE_RST;
    end else begin
      side_right_q <= (slice_id >= HALF_SLICES);
    end
  end

  // Per ring, per lane busy and direction mapping
  for (genvar r = 0; r < VRUS_RINGS; r++) begin : g_ring
    for (genvar l = 0; l < VRUS_LANES; l++) begin : g_lane
      localparam int FLIP = l ^ VRUS_DIR_FLIP;
      assign phys_busy[r][l]  = activity[r][l].passing | activity[r][l].sinking;
      assign logic_busy[r][l] = side_right_q ? phys_busy[r][FLIP] : phys_busy[r][l];
    end
  end

  // Ring select and qualifier mask
  always_comb begin
    sel_busy  = '0;
    qual_mask = '0;
    unique case (sel)
      VRUS_SEL_CREDIT: begin
        sel_busy  = logic_busy[VRUS_SEL_CREDIT];
        qual_mask = ctl.qualifier[VRUS_LANES-1:0];
      end
      VRUS_SEL_ACK: begin
        sel_busy  = logic_busy[VRUS_SEL_ACK];
        qual_mask = ctl.qualifier[VRUS_LANES-1:0];
      end
      VRUS_SEL_PAYLOAD: begin
        sel_busy  = logic_busy[VRUS_SEL_PAYLOAD];
        qual_mask = ctl.qualifier[VRUS_LANES-1:0];
      end
      VRUS_SEL_INVAL: begin
        // Single ring: direction only, carried on the even lanes
        sel_busy = logic_busy[VRUS_SEL_INVAL];
        qual_mask[VRUS_Q_ASC_EVEN]  = ctl.qualifier[VRUS_Q_ASC_EVEN];
        qual_mask[VRUS_Q_DESC_EVEN] = ctl.qualifier[VRUS_Q_DESC_EVEN];
      end
      VRUS_SEL_TERT: begin
        sel_busy  = logic_busy[VRUS_SEL_TERT];
        qual_mask = ctl.qualifier[VRUS_LANES-1:0];
      end
      VRUS_SEL_NONE: begin
        sel_busy  = '0;
        qual_mask = '0;
      end
    endcase
  end

  assign hit_lanes = sel_busy & qual_mask;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      count_inc_q <= VRUS_INC_RST;
    end else begin
      count_inc_q <= count_enable & (|hit_lanes);
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      event_known_q <= 1'b0;
      lane_busy_q   <= '0;
    end else begin
      event_known_q <= (sel != VRUS_SEL_NONE);
      lane_busy_q   <= hit_lanes;
    end
  end

  assign count_inc     = count_inc_q;
  assign event_known   = event_known_q;
  assign stop_on_right = side_right_q;
  assign lane_busy     = lane_busy_q;

endmodule

// ==== sim/vrus_properties.sv ====
// Port checker for the ring usage counter
`timescale 1ns/10ps
module vrus_properties #(parameter int SLICE_COUNT = 40, SLICE_ID_W = 6) (
  input logic                  core_clk,
  input logic                  rst_n,
  input vrus_pkg::vrus_ctl_t   ctl,
  input logic                  count_enable,
  input logic [SLICE_ID_W-1:0] slice_id,
  input vrus_pkg::vrus_stop_t  activity,
  input logic                  count_inc,
  input logic                  event_known,
  input logic                  stop_on_right,
  input logic [3:0]            lane_busy
);
  import vrus_pkg::*;
  logic [3:0] lb;
  logic       kn;
  int         r;
  assign kn = ctl.event_code inside {[8'hb1:8'hb5]};
  always_comb begin
    r = int'(ctl.event_code[2:0]) - int'(ctl.event_code == VRUS_EVT_TERT);
    if (ctl.event_code == VRUS_EVT_CREDIT) r = 0;
    for (int l = 0; l < 4; l++)
      lb[l] = |activity[r][l ^ {stop_on_right, 1'b0}][2:1] & ctl.qualifier[l]
        & !(r == 3 && l[0]);
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  sequence s_off; !count_enable[*2]; endsequence
  property p_inc; $past(rst_n) |-> count_inc == $past(count_enable & kn & |lb); endproperty
  a_inc: assert property (p_inc) else $error("inc");
  property p_kn; $past(rst_n) |-> event_known == $past(kn); endproperty
  a_kn: assert property (p_kn) else $error("known");
  property p_side; $past(rst_n) |-> stop_on_right == $past(slice_id >= SLICE_COUNT / 2); endproperty
  a_side: assert property (p_side) else $error("side");
  property p_off; s_off |-> !count_inc ##1 !count_inc; endproperty
  a_off: assert property (p_off) else $error("off");
  property p_tie; count_inc |-> event_known; endproperty
  a_tie: assert property (p_tie) else $error("tie");
  property p_lane; $past(rst_n) |-> lane_busy == $past(kn ? lb : 4'h0); endproperty
  a_lane: assert property (p_lane) else $error("lane");
endmodule
bind vrus_ring_usage_counter vrus_properties #(.SLICE_COUNT(SLICE_COUNT), .SLICE_ID_W(SLICE_ID_W))
  u_props (.core_clk, .rst_n, .ctl, .count_enable, .slice_id, .activity, .count_inc,
  .event_known, .stop_on_right, .lane_busy);

// ==== sim/vrus_ring_model.sv ====
// Ring stop activity source
`timescale 1ns/10ps
module vrus_ring_model (
  input  logic [2:0]           ring,
  input  logic [3:0]           lanes,
  input  logic [2:0]           kind,
  output vrus_pkg::vrus_stop_t activity
);
  import vrus_pkg::*;
  always_comb begin
    activity = {20{3'h1}};
    for (int l = 0; l < 4; l++)
      if (lanes[l] && !(ring == 3 && l[0])) activity[ring][l] = kind;
  end
endmodule

// ==== sim/vrus_ring_usage_counter_bench.sv ====
// Bench for the ring usage counter
`timescale 1ns/10ps
module vrus_ring_usage_counter_bench;
  import vrus_pkg::*;
  logic       core_clk = 0, rst_n = 0, count_enable = 1, count_inc;
  logic [3:0] slice_id = 4'h3, lanes = 4'h0;
  logic [2:0] ring = 3'h0, kind = 3'h4;
  logic [7:0] codes [5] = '{8'hb4, 8'hb1, 8'hb2, 8'hb3, 8'hb5};
  vrus_ctl_t  ctl = 16'h0;
  vrus_stop_t activity;
  int         n_mismatch = 0, comparisons = 0, cyc = 0;
  vrus_ring_model model (.ring, .lanes, .kind, .activity);
  vrus_ring_usage_counter #(.SLICE_COUNT(8), .SLICE_ID_W(4)) uut (.core_clk, .rst_n, .ctl,
    .count_enable, .slice_id, .activity, .count_inc, .event_known(), .stop_on_right(),
    .lane_busy());
  always #2.5 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 400) begin
      n_mismatch++;
      conclude();
    end
  end
  task automatic conclude;
    if (n_mismatch == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(logic [15:0] c, logic [2:0] g, logic [3:0] ln, logic e, logic [2:0] k = 4);
    @(posedge core_clk);
    {ctl, ring, lanes, kind} <= {c, g, ln, k};
    @(posedge core_clk);
    #1;
    comparisons++;
    if (count_inc !== e) begin
      n_mismatch++;
      $display("BAD count_inc ctl %h exp %b got %b", c, e, count_inc);
    end
  endtask
  initial begin
    repeat (2) @(posedge core_clk);
    rst_n <= 1;
    for (int i = 0; i < 5; i++) begin
      chk({8'h05, codes[i]}, 3'(i), 4'h1, 1);
      chk({8'h05, codes[i]}, 3'((i + 1) % 5), 4'h1, 0);
    end
    chk(16'h01b1, 3'h1, 4'h1, 1, 3'h2);
    chk(16'h01b1, 3'h1, 4'h1, 0, 3'h1);
    for (int l = 0; l < 4; l++) begin
      chk({8'(1 << l), 8'hb2}, 3'h2, 4'(1 << l), 1);
      chk({8'(1 << l), 8'hb2}, 3'h2, 4'(1 << (l ^ 1)), 0);
    end
    @(posedge core_clk) slice_id <= 4'h4;
    for (int l = 0; l < 4; l++) begin
      chk({8'(1 << l), 8'hb5}, 3'h4, 4'(1 << (l ^ 2)), 1);
      chk({8'(1 << l), 8'hb5}, 3'h4, 4'(1 << l), 0);
    end
    chk(16'h0ab3, 3'h3, 4'h5, 0);
    chk(16'h04b3, 3'h3, 4'h1, 1);
    chk(16'h0fb1, 3'h1, 4'hf, 1, 3'h6);
    chk(16'h0fb0, 3'h0, 4'hf, 0);
    @(posedge core_clk) count_enable <= 0;
    chk(16'h0fb1, 3'h1, 4'hf, 0);
    conclude();
  end
endmodule
